/* File: hdl/tfs_pkg.sv */
// Package of constants for the drive I/O terminal function select
package tfs_pkg;
  // ---------------------------------------------------------------------------
  // Terminal counts and code widths
  // ---------------------------------------------------------------------------
  localparam int TFS_NUM_IN = 9;
  localparam int TFS_NUM_OUT = 5;
  localparam int TFS_CODE_W = 6;
  localparam int TFS_NUM_SRC = 64;
  // ---------------------------------------------------------------------------
  // Input function codes
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IN_SPEED_STEP_BIT1 = 6'h00;
  localparam logic [5:0] IN_SPEED_STEP_BIT2 = 6'h01;
  localparam logic [5:0] IN_SPEED_STEP_BIT4 = 6'h02;
  localparam logic [5:0] IN_SPEED_STEP_BIT8 = 6'h03;
  localparam logic [5:0] IN_RAMP_SELECT_BIT1 = 6'h04;
  localparam logic [5:0] IN_RAMP_SELECT_BIT2 = 6'h05;
  localparam logic [5:0] IN_SELF_HOLD = 6'h06;
  localparam logic [5:0] IN_COAST_STOP = 6'h07;
  localparam logic [5:0] IN_FAULT_CLEAR = 6'h08;
  localparam logic [5:0] IN_TORQUE_LIMIT_SEL = 6'h0e;
  // ---------------------------------------------------------------------------
  // Output function codes
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OUT_RUNNING = 6'h00;
  localparam logic [5:0] OUT_FREQ_DET_ONE = 6'h02;
  localparam logic [5:0] OUT_UNDERVOLT = 6'h03;
  localparam logic [5:0] OUT_TORQUE_POL = 6'h04;
  localparam logic [5:0] OUT_RESTART = 6'h06;
  localparam logic [5:0] OUT_OVERLOAD_WARN = 6'h07;
  localparam logic [5:0] OUT_KEYPAD = 6'h08;
  localparam logic [5:0] OUT_STOPPED = 6'h09;
  localparam logic [5:0] OUT_READY = 6'h0a;
  localparam logic [5:0] OUT_LINE_CTR = 6'h0b;
  localparam logic [5:0] OUT_DRV_OUT_CTR = 6'h0c;
  localparam logic [5:0] OUT_DRV_IN_CTR = 6'h0d;
  localparam logic [5:0] OUT_MOTOR2 = 6'h0e;
  localparam logic [5:0] OUT_AUX_RUN = 6'h0f;
  localparam logic [5:0] OUT_STAGE_CHG = 6'h10;
  localparam logic [5:0] OUT_CYCLE_DONE = 6'h11;
  localparam logic [5:0] OUT_STAGE_B0 = 6'h12;
  localparam logic [5:0] OUT_FAULT_B0 = 6'h15;
  localparam logic [5:0] OUT_FAN = 6'h19;
  localparam logic [5:0] OUT_RETRY = 6'h1a;
  localparam logic [5:0] OUT_SERIAL_DO = 6'h1b;
  localparam logic [5:0] OUT_HEATSINK = 6'h1c;
  localparam logic [5:0] OUT_LIFE = 6'h1e;
  localparam logic [5:0] OUT_FREQ_DET_TWO = 6'h1f;
  localparam logic [5:0] OUT_OVERLOAD_TWO = 6'h20;
  localparam logic [5:0] OUT_CUR_IN_OFF = 6'h21;
  localparam logic [5:0] OUT_TORQUE_LIM = 6'h25;
  // ---------------------------------------------------------------------------
  // Settings and register map
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TUNING_TORQUE_LIM2 = 2'h2;
  localparam logic [11:0] ADDR_IN_FUNC_BASE = 12'h000;
  localparam logic [11:0] ADDR_OUT_FUNC_BASE = 12'h040;
  localparam logic [11:0] ADDR_CONFIG = 12'h080;
  localparam logic [11:0] ADDR_STATUS = 12'h084;
  localparam logic [11:0] ADDR_SERIAL_DO = 12'h088;
  localparam int CFG_TUNING_LSB = 0;
  localparam int CFG_ZERO_RESTART = 2;
  localparam logic [1:0] TUNING_RESET = 2'h0;
endpackage : tfs_pkg

/* File: hdl/tfs_terminal_select.sv */
// Terminal function routing of a drive with an APB register file
`timescale 1ns/10ps
module tfs_terminal_select import tfs_pkg::*; #(
  parameter int NUM_IN = TFS_NUM_IN,
  parameter int NUM_OUT = TFS_NUM_OUT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input terminals (asynchronous contacts)
  input wire logic [NUM_IN-1:0] term_in,
  // Internal status sources
  input wire logic freq_nonzero,
  input wire logic dc_brake_active,
  input wire logic bus_below_level,
  input wire logic uv_protect_active,
  input wire logic torque_braking,
  input wire logic current_limit_active,
  input wire logic torque_limit_active,
  input wire logic regen_avoid_active,
  input wire logic pullin_start,
  input wire logic prior_freq_regained,
  input wire logic freq_level_detect_one,
  input wire logic freq_level_detect_two,
  input wire logic overload_early_warn,
  input wire logic overload_level_two,
  input wire logic keypad_operation_ind,
  input wire logic ready_ind,
  input wire logic line_contactor_ctrl,
  input wire logic drive_output_contactor_ctrl,
  input wire logic drive_input_contactor_ctrl,
  input wire logic second_motor_switch,
  input wire logic auxiliary_run_out,
  input wire logic stage_change_pulse,
  input wire logic pattern_cycle_done_pulse,
  input wire logic [2:0] stage_number,
  input wire logic [3:0] fault_code,
  input wire logic fan_running,
  input wire logic retry_active,
  input wire logic heatsink_overheat_warn,
  input wire logic life_alert,
  input wire logic current_input_off_flag,
  input wire logic delayed_torque_limit_flag,
  // Decoded input functions
  output logic [3:0] speed_step,
  output logic [1:0] ramp_pair_sel,
  output logic self_hold_input,
  output logic coast_stop_input,
  output logic fault_clear_input,
  output logic torque_limit2_sel,
  // Output terminals
  output logic [NUM_OUT-1:0] term_out
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_IN-1:0][5:0] in_code;
    logic [NUM_OUT-1:0][5:0] out_code;
    logic [1:0] motor_tuning_setting;
    logic zero_restart;
    logic serial_do;
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic restart_ind;
    logic [NUM_OUT-1:0] term;
    logic [31:0] rdata;
  } tfs_state_t;

  tfs_state_t st_q;
  tfs_state_t st_d;
  logic running;
  logic stopped_ind;
  logic undervoltage_flag;
  logic torque_limiting_flag;
  logic [TFS_NUM_SRC-1:0] src;
  logic wr_en;
  logic rd_en;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ---------------------------------------------------------------------------
  // Reset codes and status sources
  // ---------------------------------------------------------------------------
  // Factory codes: terminal n carries function n
  function automatic logic [NUM_IN-1:0][5:0] reset_codes();
    logic [NUM_IN-1:0][5:0] codes;
    for (int n = 0; n < NUM_IN; n++) begin
      codes[n] = 6'(n);
    end
    return codes;
  endfunction

  localparam logic [NUM_IN-1:0][5:0] IN_RST = reset_codes();

  assign running = freq_nonzero && !dc_brake_active;
  assign stopped_ind = !running || dc_brake_active;
  assign undervoltage_flag = bus_below_level || uv_protect_active;
  assign torque_limiting_flag = current_limit_active || torque_limit_active ||
                                regen_avoid_active;

  always_comb begin
    src = '0;
    src[OUT_RUNNING] = running;
    src[OUT_FREQ_DET_ONE] = freq_level_detect_one;
    src[OUT_UNDERVOLT] = undervoltage_flag;
    src[OUT_TORQUE_POL] = torque_braking;
    src[OUT_RESTART] = st_q.restart_ind;
    src[OUT_OVERLOAD_WARN] = overload_early_warn;
    src[OUT_KEYPAD] = keypad_operation_ind;
    src[OUT_STOPPED] = stopped_ind;
    src[OUT_READY] = ready_ind;
    src[OUT_LINE_CTR] = line_contactor_ctrl;
    src[OUT_DRV_OUT_CTR] = drive_output_contactor_ctrl;
    src[OUT_DRV_IN_CTR] = drive_input_contactor_ctrl;
    src[OUT_MOTOR2] = second_motor_switch;
    src[OUT_AUX_RUN] = auxiliary_run_out;
    src[OUT_STAGE_CHG] = stage_change_pulse;
    src[OUT_CYCLE_DONE] = pattern_cycle_done_pulse;
    src[OUT_STAGE_B0 +: 3] = stage_number;
    src[OUT_FAULT_B0 +: 4] = fault_code;
    src[OUT_FAN] = fan_running;
    src[OUT_RETRY] = retry_active;
    src[OUT_SERIAL_DO] = st_q.serial_do;
    src[OUT_HEATSINK] = heatsink_overheat_warn;
    src[OUT_LIFE] = life_alert;
    src[OUT_FREQ_DET_TWO] = freq_level_detect_two;
    src[OUT_OVERLOAD_TWO] = overload_level_two;
    src[OUT_CUR_IN_OFF] = current_input_off_flag;
    src[OUT_TORQUE_LIM] = delayed_torque_limit_flag;
  end

  // ---------------------------------------------------------------------------
  // Input function decode
  // ---------------------------------------------------------------------------
  always_comb begin
    speed_step = '0;
    ramp_pair_sel = '0;
    self_hold_input = 1'b0;
    coast_stop_input = 1'b0;
    fault_clear_input = 1'b0;
    torque_limit2_sel = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (st_q.sync2[i]) begin
        unique case (st_q.in_code[i])
          IN_SPEED_STEP_BIT1: speed_step[0] = 1'b1;
          IN_SPEED_STEP_BIT2: speed_step[1] = 1'b1;
          IN_SPEED_STEP_BIT4: speed_step[2] = 1'b1;
          IN_SPEED_STEP_BIT8: speed_step[3] = 1'b1;
          IN_RAMP_SELECT_BIT1: ramp_pair_sel[0] = 1'b1;
          IN_RAMP_SELECT_BIT2: ramp_pair_sel[1] = 1'b1;
          IN_SELF_HOLD: self_hold_input = 1'b1;
          IN_COAST_STOP: coast_stop_input = 1'b1;
          IN_FAULT_CLEAR: fault_clear_input = 1'b1;
          IN_TORQUE_LIMIT_SEL: begin
            torque_limit2_sel = (st_q.motor_tuning_setting == TUNING_TORQUE_LIM2);
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync1 = term_in;
    st_d.sync2 = st_q.sync1;
    // Restart indication: zero restart clears first, then set wins over clear on regain
    if (st_q.zero_restart) begin
      st_d.restart_ind = 1'b0;
    end else if (pullin_start) begin
      st_d.restart_ind = 1'b1;
    end else if (prior_freq_regained) begin
      st_d.restart_ind = 1'b0;
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      st_d.term[j] = src[st_q.out_code[j]];
    end
    if (wr_en) begin
      for (int k = 0; k < NUM_IN; k++) begin
        if (paddr == ADDR_IN_FUNC_BASE + 12'(4 * k)) begin
          st_d.in_code[k] = pwdata[5:0];
        end
      end
      for (int k = 0; k < NUM_OUT; k++) begin
        if (paddr == ADDR_OUT_FUNC_BASE + 12'(4 * k)) begin
          st_d.out_code[k] = pwdata[5:0];
        end
      end
      if (paddr == ADDR_CONFIG) begin
        st_d.motor_tuning_setting = pwdata[CFG_TUNING_LSB +: 2];
        st_d.zero_restart = pwdata[CFG_ZERO_RESTART];
      end
      if (paddr == ADDR_SERIAL_DO) begin
        st_d.serial_do = pwdata[0];
      end
    end
    if (rd_en) begin
      st_d.rdata = '0;
      for (int k = 0; k < NUM_IN; k++) begin
        if (paddr == ADDR_IN_FUNC_BASE + 12'(4 * k)) begin
          st_d.rdata[5:0] = st_q.in_code[k];
        end
      end
      for (int k = 0; k < NUM_OUT; k++) begin
        if (paddr == ADDR_OUT_FUNC_BASE + 12'(4 * k)) begin
          st_d.rdata[5:0] = st_q.out_code[k];
        end
      end
      if (paddr == ADDR_CONFIG) begin
        st_d.rdata[CFG_TUNING_LSB +: 2] = st_q.motor_tuning_setting;
        st_d.rdata[CFG_ZERO_RESTART] = st_q.zero_restart;
      end
      if (paddr == ADDR_STATUS) begin
        st_d.rdata[NUM_OUT-1:0] = st_q.term;
        st_d.rdata[16 +: NUM_IN] = st_q.sync2;
      end
      if (paddr == ADDR_SERIAL_DO) begin
        st_d.rdata[0] = st_q.serial_do;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.in_code <= IN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign term_out = st_q.term;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  out_route_a: assert property (
    st_q.out_code[0] == OUT_STOPPED && $stable(st_q.out_code[0])
      |=> term_out[0] == $past(stopped_ind)
  ) else $error("Terminal 0 route wrong");

  unused_off_a: assert property (
    st_q.out_code[0] == 6'h1d |=> !term_out[0]
  ) else $error("Unused code drives terminal");

  run_brake_a: assert property (
    dc_brake_active |-> !running && stopped_ind
  ) else $error("Running during DC braking");

  run_src_a: assert property (
    freq_nonzero && !dc_brake_active |-> running
  ) else $error("Running missing at nonzero frequency");

  stop_inv_a: assert property (
    !dc_brake_active |-> stopped_ind != running
  ) else $error("Stopped not inverse of running");

  undervolt_a: assert property (
    uv_protect_active |-> undervoltage_flag
  ) else $error("Undervoltage flag dropped");

  tlim_flag_a: assert property (
    regen_avoid_active |-> torque_limiting_flag
  ) else $error("Torque limiting flag missing");

  tpol_a: assert property (
    st_q.out_code[0] == OUT_TORQUE_POL && $stable(st_q.out_code[0])
      |=> term_out[0] == $past(torque_braking)
  ) else $error("Torque polarity route wrong");

  zero_rst_a: assert property (
    st_q.zero_restart |=> !st_q.restart_ind
  ) else $error("Restart shown under zero restart");

  restart_set_a: assert property (
    !st_q.zero_restart && pullin_start |=> st_q.restart_ind
  ) else $error("Restart not set on pull-in");

  restart_clr_a: assert property (
    !pullin_start && prior_freq_regained |=> !st_q.restart_ind
  ) else $error("Restart not cleared on regain");

  tlim2_gate_a: assert property (
    st_q.motor_tuning_setting != TUNING_TORQUE_LIM2 |-> !torque_limit2_sel
  ) else $error("Torque limit two without tuning");

  reset_codes_a: assert property (
    $rose(rst_n) |-> st_q.in_code == IN_RST
  ) else $error("Input codes not at factory values");

  // ---------------------------------------------------------------------------
  // Per-terminal checks
  // ---------------------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < NUM_OUT; gc++) begin : g_out_chk
      term_route_a: assert property (
        rst_n |=> term_out[gc] == $past(src[st_q.out_code[gc]])
      ) else $error("Output terminal route wrong");
    end
    for (gc = 0; gc < NUM_IN; gc++) begin : g_in_chk
      ramp_one_a: assert property (
        st_q.sync2[gc] && st_q.in_code[gc] == IN_RAMP_SELECT_BIT1 |-> ramp_pair_sel[0]
      ) else $error("Ramp select bit one lost");

      ramp_two_a: assert property (
        st_q.sync2[gc] && st_q.in_code[gc] == IN_RAMP_SELECT_BIT2 |-> ramp_pair_sel[1]
      ) else $error("Ramp select bit two lost");

      tlim2_on_a: assert property (
        st_q.sync2[gc] && st_q.in_code[gc] == IN_TORQUE_LIMIT_SEL &&
          st_q.motor_tuning_setting == TUNING_TORQUE_LIM2 |-> torque_limit2_sel
      ) else $error("Torque limit two not selected");

      hold_dec_a: assert property (
        st_q.sync2[gc] && st_q.in_code[gc] == IN_SELF_HOLD |-> self_hold_input
      ) else $error("Self-hold input lost");
    end
  endgenerate

  restart_c: cover property (pullin_start ##[1:20] prior_freq_regained);
  ramp_c: cover property (ramp_pair_sel == 2'h3);
  tlim2_c: cover property (torque_limit2_sel);
  zero_rst_c: cover property (st_q.zero_restart && pullin_start);
  unused_c: cover property (st_q.out_code[0] == 6'h1d);
endmodule : tfs_terminal_select

/* File: dv/tfs_contact_bank.sv */
// Far-side model: control contacts feeding the inputs, relays on the outputs
`timescale 1ns/10ps
module tfs_contact_bank import tfs_pkg::*; (
  // Contact commands from the bench
  input wire logic [TFS_NUM_IN-1:0] closed,
  // Terminal wiring
  output logic [TFS_NUM_IN-1:0] term_in,
  input wire logic [TFS_NUM_OUT-1:0] term_out,
  // Relay coil states
  output logic [TFS_NUM_OUT-1:0] coil
);
  // Closed contact pulls its terminal high, open one lets it fall low
  assign term_in = closed;
  assign coil = term_out;
endmodule // tfs_contact_bank

/* File: dv/tfs_terminal_select_test.sv */
// Self-checking bench for the terminal function select block
`timescale 1ns/10ps
module tfs_terminal_select_test import tfs_pkg::*;;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, hold, coast, clr, tl2;
  logic [8:0] closed = '0, term_in;
  logic [35:0] s = '0;
  logic [3:0] speed;
  logic [1:0] ramp;
  logic [4:0] term_out;
  int bad_count = 0, tests_run = 0;
  int cd[27] = '{2,4,7,8,10,11,12,13,14,15,16,17,18,19,20,21,22,23,24,25,26,28,30,31,32,33,37};
  int bt[27] = '{10,4,12,14,15,16,17,18,19,20,21,22,23,24,25,26,27,28,29,30,31,32,33,11,13,34,35};
  always #50 core_clk = ~core_clk;
  tfs_contact_bank bank (.closed(closed), .term_in(term_in), .term_out(term_out), .coil());
  tfs_terminal_select dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_in(term_in), .freq_nonzero(s[0]), .dc_brake_active(s[1]),
    .bus_below_level(s[2]), .uv_protect_active(s[3]), .torque_braking(s[4]),
    .current_limit_active(s[5]), .torque_limit_active(s[6]), .regen_avoid_active(s[7]),
    .pullin_start(s[8]), .prior_freq_regained(s[9]), .freq_level_detect_one(s[10]),
    .freq_level_detect_two(s[11]), .overload_early_warn(s[12]), .overload_level_two(s[13]),
    .keypad_operation_ind(s[14]), .ready_ind(s[15]), .line_contactor_ctrl(s[16]),
    .drive_output_contactor_ctrl(s[17]), .drive_input_contactor_ctrl(s[18]),
    .second_motor_switch(s[19]), .auxiliary_run_out(s[20]), .stage_change_pulse(s[21]),
    .pattern_cycle_done_pulse(s[22]), .stage_number(s[25:23]), .fault_code(s[29:26]),
    .fan_running(s[30]), .retry_active(s[31]), .heatsink_overheat_warn(s[32]),
    .life_alert(s[33]), .current_input_off_flag(s[34]), .delayed_torque_limit_flag(s[35]),
    .speed_step(speed), .ramp_pair_sel(ramp), .self_hold_input(hold),
    .coast_stop_input(coast), .fault_clear_input(clr), .torque_limit2_sel(tl2),
    .term_out(term_out));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("Error at %0t: no bus answer", $time);
      close_out();
    end
  endtask
  task automatic drive(input logic [35:0] v, input logic [8:0] c);
    @(posedge core_clk);
    s <= v;
    closed <= c;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [11:0] oa(input int t);
    return ADDR_OUT_FUNC_BASE + 12'(4 * t);
  endfunction
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_defaults();
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, ADDR_IN_FUNC_BASE + 12'(4 * k), '0);
      chk(q, 32'(k), "input code");
    end
    apb(1'b0, oa(4), '0);
    chk(q, 32'h0, "output code");
    apb(1'b1, 12'h0fc, 32'h0000_00ff);
    apb(1'b0, 12'h0fc, '0);
    chk(q, 32'h0, "unmapped");
    drive('0, 9'h1cf);
    chk({24'h0, speed, hold, coast, clr, 1'b0}, 32'hfe, "decode");
    for (int r = 0; r < 4; r++) begin
      drive(36'h1, 9'(r << 4));
      chk(32'(ramp), 32'(r), "ramp pair");
    end
    $display("defaults and ramp test done");
  endtask
  task automatic t_torque();
    apb(1'b1, ADDR_IN_FUNC_BASE, 32'(IN_TORQUE_LIMIT_SEL));
    for (int u = 0; u < 4; u++) begin
      apb(1'b1, ADDR_CONFIG, 32'(u));
      drive('0, 9'h001);
      chk(32'(tl2), 32'(u == 2), "limit two");
      drive('0, 9'h000);
      chk(32'(tl2), 32'h0, "limit one");
    end
    apb(1'b1, ADDR_CONFIG, '0);
    $display("torque limit test done");
  endtask
  task automatic t_route();
    for (int i = 0; i < 27; i++) begin
      apb(1'b1, oa(i % 5), 32'(cd[i]));
      drive('0, '0);
      chk(32'(term_out), 32'h0, "idle source");
      drive(36'h1 << bt[i], '0);
      chk(32'(term_out), 32'h1 << (i % 5), "routed source");
    end
    apb(1'b1, oa(0), 32'(OUT_SERIAL_DO));
    apb(1'b1, ADDR_SERIAL_DO, 32'h1);
    drive('0, '0);
    chk(32'(term_out[0]), 32'h1, "serial output");
    apb(1'b0, ADDR_STATUS, '0);
    chk(q, 32'h1, "status word");
    apb(1'b1, ADDR_SERIAL_DO, 32'h0);
    foreach (cd[i]) begin
      if (i < 5) begin
        apb(1'b1, oa(i), '0);
      end
    end
    $display("routing test done");
  endtask
  task automatic t_unused();
    int un[5] = '{1, 5, 29, 34, 63};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, oa(0), 32'(un[i]));
      drive('1, '0);
      chk(32'(term_out[0]), 32'h0, "unused code");
    end
    $display("unused code test done");
  endtask
  task automatic t_derived();
    apb(1'b1, oa(0), 32'(OUT_RUNNING));
    drive(36'h1, '0);
    chk(32'(term_out[0]), 32'h1, "running");
    drive(36'h3, '0);
    chk(32'(term_out[0]), 32'h0, "running in braking");
    apb(1'b1, oa(0), 32'(OUT_STOPPED));
    drive(36'h3, '0);
    chk(32'(term_out[0]), 32'h1, "stopped in braking");
    drive(36'h1, '0);
    chk(32'(term_out[0]), 32'h0, "stopped while running");
    drive(36'h0, '0);
    chk(32'(term_out[0]), 32'h1, "stopped at rest");
    apb(1'b1, oa(0), 32'(OUT_UNDERVOLT));
    drive(36'h4, '0);
    chk(32'(term_out[0]), 32'h1, "bus low");
    drive(36'h8, '0);
    chk(32'(term_out[0]), 32'h1, "protection held");
    drive(36'h0, '0);
    chk(32'(term_out[0]), 32'h0, "recovered");
    apb(1'b1, oa(0), 32'(OUT_RESTART));
    drive(36'h100, '0);
    drive(36'h0, '0);
    chk(32'(term_out[0]), 32'h1, "pull-in");
    drive(36'h200, '0);
    drive(36'h0, '0);
    chk(32'(term_out[0]), 32'h0, "regained");
    apb(1'b1, ADDR_CONFIG, 32'h4);
    drive(36'h100, '0);
    chk(32'(term_out[0]), 32'h0, "zero restart");
    apb(1'b1, ADDR_CONFIG, '0);
    $display("derived status test done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_defaults();
    t_torque();
    t_route();
    t_unused();
    t_derived();
    close_out();
  end
endmodule // tfs_terminal_select_test
